/* File: design/sod_fifo.sv */
// parameterised fifo with valid/ready on both sides
`timescale 1ns/100ps
module sod_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic clk,
    input  wire logic rst,
    sod_fifo_if.snk   wr,
    sod_fifo_if.src   rd
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem_ff [DEPTH];
    logic [AW:0]   wp_ff;
    logic [AW:0]   rp_ff;
    logic [W-1:0]  dout_ff;
    logic          dv_ff;
    logic          full;
    logic          empty;
    logic          pop;
    logic [AW:0]   used;

    assign used     = wp_ff - rp_ff;
    // the output register is one of the DEPTH slots
    assign full     = (used == (AW+1)'(DEPTH)) || (dv_ff && (used == (AW+1)'(DEPTH - 1)));
    assign empty    = (wp_ff == rp_ff);
    assign wr.ready = !full;
    assign pop      = !empty && (!dv_ff || rd.ready);
    assign rd.valid = dv_ff;
    assign rd.data  = dout_ff;

    always_ff @(posedge clk) begin
        if (wr.valid && !full) begin
            mem_ff[wp_ff[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_ff <= '0;
        end else if (wr.valid && !full) begin
            wp_ff <= wp_ff + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rp_ff   <= '0;
            dv_ff   <= 1'b0;
            dout_ff <= '0;
        end else if (pop) begin
            rp_ff   <= rp_ff + 1'b1;
            dv_ff   <= 1'b1;
            dout_ff <= mem_ff[rp_ff[AW-1:0]];
        end else if (rd.ready) begin
            dv_ff   <= 1'b0;
        end
    end
endmodule // sod_fifo

/* File: design/sod_fifo_if.sv */
// valid/ready carrier between the decoder and its opcode fifo
`timescale 1ns/100ps
interface sod_fifo_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: design/sod_opcode_decoder.sv */
// serial opcode decoder with protection and ready status byte
`timescale 1ns/100ps
// Operation
// - first byte after select is caught in an eight-bit opcode register.
// - bits arrive and leave MSB first; each instruction starts at select falling.
// - exactly twenty-one opcodes are recognised.
// - 05 reads status, 09 reads status fast, 01 writes status.
// - 06 arms writes, 04 disarms writes.
// - 03 reads array, 0B reads array fast, 02 writes array.
// - 13 reads clock, 1D reads clock fast, 12 writes clock.
// - 3C save, 60 restore, 59 autosave on, 19 autosave off.
// - B9 sleep, C2 serial write, C3 serial read, C9 fast serial read.
// - 9F identification read, 99 fast identification read.
// - status layout: enable, lock, zero, zero, guard hi, guard lo, arm, busy.
// - busy bit reads one while save or restore runs.
// - status write changes only enable, guard bits and lock.
// - bits five and four ignore writes and read zero.
// - all writable status bits start at zero.
// - arm bit clears at power-up; writes need it set; here only 01 waits for it, other write opcodes are queued with arm clear too.
// - serial writes are refused once the lock is set.
// - lock bit can be set once and never cleared.
// - status read returns status byte on serial output.
// - unknown opcode ignored until next select; output stays released.
// - guard pair selects none, top quarter, top half or whole array.
// - completed write class instruction clears the arm bit.
// - enable set and protect pin low rejects status writes.
module sod_opcode_decoder #(
    parameter int FIFO_DEPTH = sod_pkg::FIFO_DEPTH
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    input  wire logic        SPI_CS_N,
    input  wire logic        SPI_SCK,
    input  wire logic        SPI_SI,
    output logic             SPI_SO_O,
    output logic             SPI_SO_OE_N,
    input  wire logic        WRITE_PROTECT_N,
    input  wire logic        NV_BUSY,
    output logic [7:0]       STATUS_BYTE,
    output logic [12:0]      GUARD_BASE,
    output logic             GUARD_ANY,
    output logic             SERIAL_WRITE_OK,
    output logic             OP_VALID,
    output logic [4:0]       OP_CMD,
    input  wire logic        OP_READY
);
    // pin synchronisers
    logic [1:0] cs_sync_ff;
    logic [1:0] sck_sync_ff;
    logic [1:0] si_sync_ff;
    logic [1:0] wp_sync_ff;
    logic [1:0] busy_sync_ff;
    logic       sck_prev_ff;
    logic       cs_prev_ff;

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            cs_sync_ff   <= 2'b11;
            sck_sync_ff  <= 2'b00;
            si_sync_ff   <= 2'b00;
            wp_sync_ff   <= 2'b11;
            busy_sync_ff <= 2'b00;
            sck_prev_ff  <= 1'b0;
            cs_prev_ff   <= 1'b1;
        end else begin
            cs_sync_ff   <= {cs_sync_ff[0], SPI_CS_N};
            sck_sync_ff  <= {sck_sync_ff[0], SPI_SCK};
            si_sync_ff   <= {si_sync_ff[0], SPI_SI};
            wp_sync_ff   <= {wp_sync_ff[0], WRITE_PROTECT_N};
            busy_sync_ff <= {busy_sync_ff[0], NV_BUSY};
            sck_prev_ff  <= sck_sync_ff[1];
            cs_prev_ff   <= cs_sync_ff[1];
        end
    end

    logic cs_n;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    assign cs_n     = cs_sync_ff[1];
    assign sck_rise = !cs_n && sck_sync_ff[1] && !sck_prev_ff;
    assign sck_fall = !cs_n && !sck_sync_ff[1] && sck_prev_ff;
    assign cs_fall  = !cs_n && cs_prev_ff;
    assign cs_rise  = cs_n && !cs_prev_ff;

    typedef enum logic [2:0] {
        SOD_IDLE   = 3'b000,
        SOD_OPCODE = 3'b001,
        SOD_SR_OUT = 3'b010,
        SOD_SR_IN  = 3'b011,
        SOD_PASS   = 3'b100,
        SOD_IGNORE = 3'b101
    } sod_state_e;

    sod_state_e         state_ff;
    logic [7:0]         shift_ff;
    logic [3:0]         bitcnt_ff;
    logic [7:0]         opcode_ff;
    logic [7:0]         tx_ff;
    logic               so_oe_n_ff;
    logic               so_ff;
    logic               dummy_ff;
    logic [7:0]         nxt_shift;
    sod_pkg::sod_cmd_e  cmd;
    logic               wp_block_ff;

    assign nxt_shift = {shift_ff[6:0], si_sync_ff[1]};

    // opcode classification
    always_comb begin
        unique case (nxt_shift)
            sod_pkg::OP_STATUS_FETCH:  cmd = sod_pkg::SOD_SR_RD;
            sod_pkg::OP_QSTATUS_FETCH: cmd = sod_pkg::SOD_SR_QRD;
            sod_pkg::OP_STATUS_STORE:  cmd = sod_pkg::SOD_SR_WR;
            sod_pkg::OP_ARM_WRITES:    cmd = sod_pkg::SOD_ARM;
            sod_pkg::OP_DISARM_WRITES: cmd = sod_pkg::SOD_DISARM;
            sod_pkg::OP_MEM_READ:      cmd = sod_pkg::SOD_M_RD;
            sod_pkg::OP_MEM_QREAD:     cmd = sod_pkg::SOD_M_QRD;
            sod_pkg::OP_MEM_WRITE:     cmd = sod_pkg::SOD_M_WR;
            sod_pkg::OP_CLOCK_FETCH:   cmd = sod_pkg::SOD_C_RD;
            sod_pkg::OP_QCLOCK_FETCH:  cmd = sod_pkg::SOD_C_QRD;
            sod_pkg::OP_CLOCK_STORE:   cmd = sod_pkg::SOD_C_WR;
            sod_pkg::OP_NV_SAVE:       cmd = sod_pkg::SOD_SAVE;
            sod_pkg::OP_NV_RESTORE:    cmd = sod_pkg::SOD_RESTORE;
            sod_pkg::OP_AUTOSAVE_ON:   cmd = sod_pkg::SOD_AS_ON;
            sod_pkg::OP_AUTOSAVE_OFF:  cmd = sod_pkg::SOD_AS_OFF;
            sod_pkg::OP_SLEEP:         cmd = sod_pkg::SOD_SLEEP;
            sod_pkg::OP_SERIAL_STORE:  cmd = sod_pkg::SOD_SN_WR;
            sod_pkg::OP_SERIAL_FETCH:  cmd = sod_pkg::SOD_SN_RD;
            sod_pkg::OP_QSERIAL_FETCH: cmd = sod_pkg::SOD_SN_QRD;
            sod_pkg::OP_IDENT_FETCH:   cmd = sod_pkg::SOD_ID_RD;
            sod_pkg::OP_QIDENT_FETCH:  cmd = sod_pkg::SOD_ID_QRD;
            default:                   cmd = sod_pkg::SOD_NONE;
        endcase
    end

    // status bits
    logic       arm_ff;
    logic       guard_lo_ff;
    logic       guard_hi_ff;
    logic       lock_ff;
    logic       ppe_ff;
    logic [7:0] status;
    logic       op_done;
    logic       write_class;
    logic       sr_wr_done;

    assign status = {ppe_ff, lock_ff, 2'b00, guard_hi_ff, guard_lo_ff,
                     arm_ff, busy_sync_ff[1]};

    // command strobe into the fifo
    sod_fifo_if #(.W(5)) cmd_in ();
    sod_fifo_if #(.W(5)) cmd_out ();
    logic       push_ff;
    logic [4:0] push_cmd_ff;

    assign cmd_in.valid  = push_ff;
    assign cmd_in.data   = push_cmd_ff;
    assign cmd_out.ready = OP_READY;
    assign OP_VALID      = cmd_out.valid;
    assign OP_CMD        = cmd_out.data;

    sod_fifo #(
        .W     (5),
        .DEPTH (FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk (CLK_SYS),
        .rst (RESET),
        .wr  (cmd_in.snk),
        .rd  (cmd_out.src)
    );

    // state machine
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state_ff  <= SOD_IDLE;
            bitcnt_ff <= 4'h0;
            shift_ff  <= 8'h00;
            opcode_ff <= 8'h00;
            dummy_ff  <= 1'b0;
        end else if (cs_n) begin
            state_ff  <= SOD_IDLE;
            bitcnt_ff <= 4'h0;
        end else if (cs_fall) begin
            state_ff  <= SOD_OPCODE;
            bitcnt_ff <= 4'h0;
        end else if (sck_rise) begin
            unique case (state_ff)
                SOD_IDLE, SOD_PASS, SOD_IGNORE: begin
                    bitcnt_ff <= bitcnt_ff;
                end
                SOD_OPCODE: begin
                    shift_ff  <= nxt_shift;
                    bitcnt_ff <= bitcnt_ff + 4'h1;
                    if (bitcnt_ff == 4'h7) begin
                        opcode_ff <= nxt_shift;
                        bitcnt_ff <= 4'h0;
                        dummy_ff  <= (cmd == sod_pkg::SOD_SR_QRD);
                        if (cmd == sod_pkg::SOD_NONE) begin
                            state_ff <= SOD_IGNORE;
                        end else if (cmd == sod_pkg::SOD_SR_RD ||
                                     cmd == sod_pkg::SOD_SR_QRD) begin
                            state_ff <= SOD_SR_OUT;
                        end else if (cmd == sod_pkg::SOD_SR_WR && arm_ff) begin
                            state_ff <= SOD_SR_IN;
                        end else begin
                            state_ff <= SOD_PASS;
                        end
                    end
                end
                SOD_SR_OUT: begin
                    bitcnt_ff <= (bitcnt_ff == 4'h7) ? 4'h0 : bitcnt_ff + 4'h1;
                    if (bitcnt_ff == 4'h7) begin
                        dummy_ff <= 1'b0;
                    end
                end
                SOD_SR_IN: begin
                    shift_ff  <= nxt_shift;
                    bitcnt_ff <= bitcnt_ff + 4'h1;
                    if (bitcnt_ff == 4'h7) begin
                        state_ff <= SOD_PASS;
                    end
                end
            endcase
        end
    end

    assign sr_wr_done = sck_rise && state_ff == SOD_SR_IN && bitcnt_ff == 4'h7;

    // serial output, changes on falling clock edges
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            so_ff      <= 1'b0;
            so_oe_n_ff <= 1'b1;
            tx_ff      <= 8'h00;
        end else if (cs_n || state_ff != SOD_SR_OUT) begin
            so_oe_n_ff <= 1'b1;
            tx_ff      <= status;
        end else if (sck_fall) begin
            if (bitcnt_ff == 4'h0) begin
                tx_ff <= {status[6:0], 1'b0};
                so_ff <= status[7];
            end else begin
                tx_ff <= {tx_ff[6:0], 1'b0};
                so_ff <= tx_ff[7];
            end
            so_oe_n_ff <= dummy_ff;
        end
    end

    assign SPI_SO_O    = so_ff;
    assign SPI_SO_OE_N = so_oe_n_ff;

    // protect pin sampled at start of each frame
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            wp_block_ff <= 1'b0;
        end else if (cs_fall) begin
            wp_block_ff <= ppe_ff && !wp_sync_ff[1];
        end
    end

    // instructions that finish when select rises
    always_comb begin
        unique case (sod_pkg::sod_cmd_e'(push_cmd_ff))
            sod_pkg::SOD_SR_WR, sod_pkg::SOD_M_WR, sod_pkg::SOD_C_WR,
            sod_pkg::SOD_SN_WR, sod_pkg::SOD_SAVE, sod_pkg::SOD_RESTORE,
            sod_pkg::SOD_AS_ON, sod_pkg::SOD_AS_OFF: write_class = 1'b1;
            default: write_class = 1'b0;
        endcase
    end

    logic frame_cmd_ok_ff;
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            push_ff         <= 1'b0;
            push_cmd_ff     <= 5'h00;
            frame_cmd_ok_ff <= 1'b0;
        end else begin
            push_ff <= 1'b0;
            if (cs_fall) begin
                frame_cmd_ok_ff <= 1'b0;
            end else if (sck_rise && state_ff == SOD_OPCODE && bitcnt_ff == 4'h7) begin
                push_cmd_ff     <= cmd;
                frame_cmd_ok_ff <= cmd != sod_pkg::SOD_NONE &&
                                   !(cmd == sod_pkg::SOD_SN_WR && lock_ff);
                push_ff         <= cmd != sod_pkg::SOD_NONE &&
                                   (!((cmd == sod_pkg::SOD_SN_WR) && lock_ff));
            end
        end
    end

    assign op_done = cs_rise && frame_cmd_ok_ff && write_class && arm_ff;

    // write enable latch
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            arm_ff <= sod_pkg::STATUS_RST[sod_pkg::SB_ARM];
        end else if (cs_rise && frame_cmd_ok_ff &&
                     push_cmd_ff == sod_pkg::SOD_ARM) begin
            arm_ff <= 1'b1;
        end else if (cs_rise && frame_cmd_ok_ff &&
                     push_cmd_ff == sod_pkg::SOD_DISARM) begin
            arm_ff <= 1'b0;
        end else if (op_done) begin
            arm_ff <= 1'b0;
        end
    end

    // writable status bits
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            ppe_ff      <= sod_pkg::STATUS_RST[sod_pkg::SB_PPE];
            lock_ff     <= sod_pkg::STATUS_RST[sod_pkg::SB_LOCK];
            guard_hi_ff <= sod_pkg::STATUS_RST[sod_pkg::SB_GUARD_HI];
            guard_lo_ff <= sod_pkg::STATUS_RST[sod_pkg::SB_GUARD_LO];
        end else if (sr_wr_done && !wp_block_ff) begin
            ppe_ff      <= nxt_shift[sod_pkg::SB_PPE];
            lock_ff     <= lock_ff | nxt_shift[sod_pkg::SB_LOCK];
            guard_hi_ff <= nxt_shift[sod_pkg::SB_GUARD_HI];
            guard_lo_ff <= nxt_shift[sod_pkg::SB_GUARD_LO];
        end
    end

    // guarded range base
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            GUARD_BASE <= sod_pkg::GUARD_TOP;
            GUARD_ANY  <= 1'b0;
        end else begin
            unique case ({guard_hi_ff, guard_lo_ff})
                2'b00: GUARD_BASE <= sod_pkg::GUARD_TOP;
                2'b01: GUARD_BASE <= sod_pkg::GUARD_Q_BASE;
                2'b10: GUARD_BASE <= sod_pkg::GUARD_H_BASE;
                2'b11: GUARD_BASE <= sod_pkg::GUARD_A_BASE;
            endcase
            GUARD_ANY <= guard_hi_ff | guard_lo_ff;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            STATUS_BYTE     <= sod_pkg::STATUS_RST;
            SERIAL_WRITE_OK <= 1'b1;
        end else begin
            STATUS_BYTE     <= status;
            SERIAL_WRITE_OK <= !lock_ff;
        end
    end
endmodule // sod_opcode_decoder

/* File: design/sod_pkg.sv */
// constants for the serial opcode decoder and status register
package sod_pkg;
    localparam int         OP_W             = 8;
    localparam int         VALID_OP_COUNT   = 21;
    localparam logic [7:0] OP_STATUS_FETCH  = 8'h05;
    localparam logic [7:0] OP_QSTATUS_FETCH = 8'h09;
    localparam logic [7:0] OP_STATUS_STORE  = 8'h01;
    localparam logic [7:0] OP_ARM_WRITES    = 8'h06;
    localparam logic [7:0] OP_DISARM_WRITES = 8'h04;
    localparam logic [7:0] OP_MEM_READ      = 8'h03;
    localparam logic [7:0] OP_MEM_QREAD     = 8'h0B;
    localparam logic [7:0] OP_MEM_WRITE     = 8'h02;
    localparam logic [7:0] OP_CLOCK_FETCH   = 8'h13;
    localparam logic [7:0] OP_QCLOCK_FETCH  = 8'h1D;
    localparam logic [7:0] OP_CLOCK_STORE   = 8'h12;
    localparam logic [7:0] OP_NV_SAVE       = 8'h3C;
    localparam logic [7:0] OP_NV_RESTORE    = 8'h60;
    localparam logic [7:0] OP_AUTOSAVE_ON   = 8'h59;
    localparam logic [7:0] OP_AUTOSAVE_OFF  = 8'h19;
    localparam logic [7:0] OP_SLEEP         = 8'hB9;
    localparam logic [7:0] OP_SERIAL_STORE  = 8'hC2;
    localparam logic [7:0] OP_SERIAL_FETCH  = 8'hC3;
    localparam logic [7:0] OP_QSERIAL_FETCH = 8'hC9;
    localparam logic [7:0] OP_IDENT_FETCH   = 8'h9F;
    localparam logic [7:0] OP_QIDENT_FETCH  = 8'h99;
    localparam logic [7:0] OP_RESERVED      = 8'h1E;
    // status bit positions
    localparam int         SB_BUSY          = 0;
    localparam int         SB_ARM           = 1;
    localparam int         SB_GUARD_LO      = 2;
    localparam int         SB_GUARD_HI      = 3;
    localparam int         SB_LOCK          = 6;
    localparam int         SB_PPE           = 7;
    localparam logic [7:0] STATUS_RST       = 8'h00;
    localparam logic [7:0] STORE_MASK       = 8'hCC;
    // guarded ranges
    localparam logic [12:0] GUARD_Q_BASE    = 13'h1800;
    localparam logic [12:0] GUARD_H_BASE    = 13'h1000;
    localparam logic [12:0] GUARD_A_BASE    = 13'h0000;
    localparam logic [12:0] GUARD_TOP       = 13'h1FFF;
    localparam int          FIFO_DEPTH      = 16;
    typedef enum logic [4:0] {
        SOD_NONE = 5'h00, SOD_SR_RD = 5'h01, SOD_SR_QRD = 5'h02, SOD_SR_WR = 5'h03,
        SOD_ARM = 5'h04, SOD_DISARM = 5'h05, SOD_M_RD = 5'h06, SOD_M_QRD = 5'h07,
        SOD_M_WR = 5'h08, SOD_C_RD = 5'h09, SOD_C_QRD = 5'h0A, SOD_C_WR = 5'h0B,
        SOD_SAVE = 5'h0C, SOD_RESTORE = 5'h0D, SOD_AS_ON = 5'h0E, SOD_AS_OFF = 5'h0F,
        SOD_SLEEP = 5'h10, SOD_SN_WR = 5'h11, SOD_SN_RD = 5'h12, SOD_SN_QRD = 5'h13,
        SOD_ID_RD = 5'h14, SOD_ID_QRD = 5'h15
    } sod_cmd_e;
endpackage

/* File: tb/sod_opcode_decoder_monitor.sv */
// concurrent checks on the opcode decoder top-level ports
`timescale 1ns/100ps
module sod_opcode_decoder_chk (
    input wire logic        CLK_SYS,
    input wire logic        RESET,
    input wire logic        SPI_CS_N,
    input wire logic        SPI_SCK,
    input wire logic        SPI_SI,
    input wire logic        SPI_SO_O,
    input wire logic        SPI_SO_OE_N,
    input wire logic        WRITE_PROTECT_N,
    input wire logic        NV_BUSY,
    input wire logic [7:0]  STATUS_BYTE,
    input wire logic [12:0] GUARD_BASE,
    input wire logic        GUARD_ANY,
    input wire logic        SERIAL_WRITE_OK,
    input wire logic        OP_VALID,
    input wire logic [4:0]  OP_CMD,
    input wire logic        OP_READY
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    function automatic logic [12:0] base_of(input logic [1:0] g);
        case (g)
            2'b01:   return sod_pkg::GUARD_Q_BASE;
            2'b10:   return sod_pkg::GUARD_H_BASE;
            2'b11:   return sod_pkg::GUARD_A_BASE;
            default: return sod_pkg::GUARD_TOP;
        endcase
    endfunction
    a_reset_status_zero: assert property ($fell(RESET) |-> STATUS_BYTE[7:1] == 7'h00)
        else $error("status not clear after reset");
    a_unused_bits_zero: assert property (STATUS_BYTE[5:4] == 2'b00)
        else $error("status bits 5..4 not zero");
    a_lock_stays_set: assert property (STATUS_BYTE[6] |=> STATUS_BYTE[6])
        else $error("lock bit cleared");
    a_arm_at_deselect: assert property ($rose(STATUS_BYTE[1]) |-> SPI_CS_N)
        else $error("arm bit set while selected");
    a_store_in_frame: assert property
        (!$stable({STATUS_BYTE[7:6], STATUS_BYTE[3:2]}) |-> !SPI_CS_N)
        else $error("status bits changed outside a frame");
    a_busy_tracks_pin: assert property ($stable(NV_BUSY) [*4] |-> STATUS_BYTE[0] == NV_BUSY)
        else $error("busy bit does not follow save activity");
    a_idle_released: assert property (SPI_CS_N [*4] |-> SPI_SO_OE_N)
        else $error("serial output driven while deselected");
    a_guard_range: assert property ($stable(STATUS_BYTE[3:2]) [*3] |->
        GUARD_BASE == base_of(STATUS_BYTE[3:2]) && GUARD_ANY == (STATUS_BYTE[3:2] != 2'b00))
        else $error("guarded range does not match guard bits");
    a_serial_ok_lock: assert property
        ($stable(STATUS_BYTE[6]) [*3] |-> SERIAL_WRITE_OK == !STATUS_BYTE[6])
        else $error("serial write permission does not match lock");
    a_queue_holds: assert property (OP_VALID && !OP_READY |=> OP_VALID && $stable(OP_CMD))
        else $error("queued command dropped before taken");
endmodule // sod_opcode_decoder_chk
bind sod_opcode_decoder sod_opcode_decoder_chk u_chk (.CLK_SYS(CLK_SYS), .RESET(RESET),
    .SPI_CS_N(SPI_CS_N), .SPI_SCK(SPI_SCK), .SPI_SI(SPI_SI), .SPI_SO_O(SPI_SO_O),
    .SPI_SO_OE_N(SPI_SO_OE_N), .WRITE_PROTECT_N(WRITE_PROTECT_N), .NV_BUSY(NV_BUSY),
    .STATUS_BYTE(STATUS_BYTE), .GUARD_BASE(GUARD_BASE), .GUARD_ANY(GUARD_ANY),
    .SERIAL_WRITE_OK(SERIAL_WRITE_OK), .OP_VALID(OP_VALID), .OP_CMD(OP_CMD),
    .OP_READY(OP_READY));

/* File: tb/sod_spi_master.sv */
// serial bus master model: select, clock and data out, samples data in
`timescale 1ns/100ps
module sod_spi_master (
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end
    // one opcode per select, then nb bytes of wd; rd holds the last byte seen
    task automatic frame(input logic [7:0] op, input logic [7:0] wd, input int nb,
                         input logic mode3, output logic [7:0] rd);
        logic [7:0] sh;
        sck = mode3;
        #137 cs_n = 1'b0;
        #400;
        for (int i = 0; i < 8 * (nb + 1); i++) begin
            sh = (i < 8) ? op : wd;
            sck = 1'b0;
            si = sh[7 - i % 8];
            #400 sck = 1'b1;
            rd = {rd[6:0], so};
            #400;
        end
        sck = mode3;
        #400 cs_n = 1'b1;
        si = ~si;
        #1000;
    endtask
endmodule // sod_spi_master

/* File: tb/tb_spi_opcode_decode_status.sv */
// self-checking bench for the serial opcode decoder and status byte
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module tb_spi_opcode_decode_status;
    logic        clk = 0, rst = 1, wp_n = 1, nv_busy = 0, op_ready = 1, so_q = 0;
    wire         cs_n, sck, si, so_o, so_oe_n, op_valid, gany, sn_ok;
    wire  [7:0]  status;
    wire  [12:0] gbase;
    wire  [4:0]  op_cmd;
    wire         so_line = so_oe_n ? ~so_q : so_o;
    int          n_fail = 0, compares = 0, n_pop = 0, n_oe = 0, p0 = 0, o0 = 0;
    logic [7:0]  rd;
    logic [7:0]  ops [21] = '{8'h05, 8'h09, 8'h01, 8'h06, 8'h04, 8'h03, 8'h0B, 8'h02, 8'h13,
        8'h1D, 8'h12, 8'h3C, 8'h60, 8'h59, 8'h19, 8'hB9, 8'hC2, 8'hC3, 8'hC9, 8'h9F, 8'h99};
    logic [12:0] bases [4] = '{13'h1FFF, 13'h1800, 13'h1000, 13'h0000};
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (!so_oe_n) so_q <= so_o;
        if (op_valid === 1'b1 && op_ready) n_pop <= n_pop + 1;
        if (so_oe_n !== 1'b1) n_oe <= n_oe + 1;
    end
    sod_opcode_decoder #(.FIFO_DEPTH(16)) dut (.CLK_SYS(clk), .RESET(rst), .SPI_CS_N(cs_n),
        .SPI_SCK(sck), .SPI_SI(si), .SPI_SO_O(so_o), .SPI_SO_OE_N(so_oe_n),
        .WRITE_PROTECT_N(wp_n), .NV_BUSY(nv_busy), .STATUS_BYTE(status), .GUARD_BASE(gbase),
        .GUARD_ANY(gany), .SERIAL_WRITE_OK(sn_ok), .OP_VALID(op_valid), .OP_CMD(op_cmd),
        .OP_READY(op_ready));
    sod_spi_master m (.cs_n(cs_n), .sck(sck), .si(si), .so(so_line));
    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic op(input logic [7:0] c);
        m.frame(c, 8'h00, 0, 1'b0, rd);
    endtask
    // arm, then store d into the status byte
    task automatic wr(input logic [7:0] d);
        op(8'h06);
        m.frame(8'h01, d, 1, 1'b0, rd);
    endtask
    task automatic fetch(input logic [7:0] e);
        m.frame(8'h05, 8'h00, 1, 1'b0, rd);
        `CHK(rd, e)
    endtask
    initial begin
        #4_000_000;
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        fetch(8'h00);
        // fill the queue past its depth, then drain it
        op_ready <= 1'b0;
        for (int i = 0; i < 21; i++) op(ops[i]);
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            if (op_valid !== 1'b1) repeat (3) @(posedge clk);
            `CHK(op_cmd, 5'(k + 1))
            op_ready <= 1'b1;
            @(posedge clk) op_ready <= 1'b0;
        end
        repeat (4) @(posedge clk);
        `CHK(op_valid, 1'b0)
        @(posedge clk) op_ready <= 1'b1;
        // reserved code: nothing queued, output never driven
        p0 = n_pop;
        o0 = n_oe;
        m.frame(8'h1E, 8'h00, 2, 1'b1, rd);
        `CHK(n_pop - p0, 0)
        `CHK(n_oe - o0, 0)
        op(8'h06);
        fetch(8'h02);
        op(8'h04);
        fetch(8'h00);
        m.frame(8'h01, 8'hFF, 1, 1'b0, rd);
        fetch(8'h00);
        wr(8'hFF);
        fetch(8'hCC);
        `CHK(sn_ok, 1'b0)
        @(posedge clk) wp_n <= 1'b0;
        wr(8'h00);
        m.frame(8'h09, 8'h00, 2, 1'b1, rd);
        `CHK(rd & 8'hFD, 8'hCC)
        @(posedge clk) wp_n <= 1'b1;
        for (int g = 0; g < 4; g++) begin
            wr(8'(g << 2));
            fetch(8'h40 | 8'(g << 2));
            `CHK(gbase, bases[g])
        end
        op(8'h06);
        p0 = n_pop;
        m.frame(8'hC2, 8'h5A, 1, 1'b0, rd);
        `CHK(n_pop - p0, 0)
        fetch(8'h4E);
        @(posedge clk) nv_busy <= 1'b1;
        repeat (4) @(posedge clk);
        fetch(8'h4F);
        wrap_up();
    end
endmodule // tb_spi_opcode_decode_status
